// *** hw/rps_bo_filter.sv ***
// Brown-out qualification filter on the supply comparator output
`timescale 1ns/1ps
module rps_bo_filter
  import rps_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic supply_low,
  output logic      bo_qual
);

  rps_bo_state_t st_ff;
  rps_bo_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // Count consecutive low-supply samples; any high sample restarts the count
  always_comb
  begin
    nxt_st = st_ff;
    if (!supply_low)
    begin
      nxt_st.cnt  = 3'h0;
      nxt_st.qual = 1'b0;
    end
    else if (st_ff.cnt != BO_QUAL_CYCLES)
    begin
      nxt_st.cnt  = st_ff.cnt + 3'h1;
      nxt_st.qual = (st_ff.cnt + 3'h1) == BO_QUAL_CYCLES;
    end
    else
    begin
      nxt_st.qual = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '{cnt: 3'h0, qual: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign bo_qual = st_ff.qual;

endmodule

// *** hw/rps_pkg.sv ***
// Constants, register map and shared types of the reset and power-save sequencer
package rps_pkg;

  // Register byte addresses
  localparam logic [7:0] REG_FCFG  = 8'h00;
  localparam logic [7:0] REG_WATCHDOG_CONTROL_REG  = 8'h04;
  localparam logic [7:0] REG_POWER_CONTROL_REG  = 8'h08;
  localparam logic [7:0] REG_STS   = 8'h0c;
  localparam logic [7:0] REG_MSK   = 8'h10;
  localparam logic [7:0] REG_STATE = 8'he4;
  localparam logic [7:0] REG_AUXIE = 8'he8;

  // Field positions
  localparam int SWR_BIT  = 1;
  localparam int WATCHDOG_RESET_FLAG_BIT = 2;
  localparam int EBO_BIT  = 3;
  localparam int IDL_BIT  = 0;
  localparam int PD_BIT   = 1;

  // Event bits of status and mask
  localparam int NUM_EV      = 3;
  localparam int EV_BO       = 0;
  localparam int EV_WAKE     = 1;
  localparam int EV_IDLE_END = 2;

  // State readback field positions
  localparam int ST_PS_LSB  = 0;
  localparam int ST_QUAL    = 4;
  localparam int ST_CRST    = 5;

  // Vectors and timing
  localparam logic [15:0] RESET_VEC      = 16'h0000;
  localparam logic [15:0] BO_VEC         = 16'h004b;
  localparam logic [2:0]  BO_QUAL_CYCLES = 3'h4;
  localparam logic [3:0]  RST_PULSE      = 4'h8;
  localparam int          NUM_EXT_INT    = 2;

  typedef enum logic [1:0] {
    PS_RUN,
    PS_IDLE,
    PS_PDOWN,
    PS_WAKE
  } rps_pstate_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rps_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } rps_apb_rsp_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic       qual;
  } rps_bo_state_t;

  typedef struct packed {
    logic              soft_reset_trigger;
    logic              watchdog_reset_flag;
    logic              brownout_irq_enable;
    logic              idle_request_bit;
    logic              pd;
    logic [NUM_EV-1:0] sts;
    logic [NUM_EV-1:0] msk;
    rps_pstate_t       ps;
    logic [3:0]        rcnt;
    logic              pcld;
    logic              wake;
    logic              qual_d;
    logic [31:0]       rdata;
  } rps_state_t;

  localparam rps_state_t RPS_STATE_RST = '{
    soft_reset_trigger:    1'b0,
    watchdog_reset_flag:   1'b0,
    brownout_irq_enable:    1'b0,
    idle_request_bit:    1'b0,
    pd:     1'b0,
    sts:    '0,
    msk:    '0,
    ps:     PS_RUN,
    rcnt:   4'h0,
    pcld:   1'b0,
    wake:   1'b0,
    qual_d: 1'b0,
    rdata:  32'h0000_0000
  };

endpackage

// *** hw/rps_top.sv ***
// Reset, brown-out and power-save sequencer with APB register access
`timescale 1ns/1ps
module rps_top
  import rps_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  rps_pkg::rps_apb_req_t       apb_req,
  output rps_pkg::rps_apb_rsp_t       apb_rsp,
  input  wire logic                   supply_low,
  input  wire logic                   rst_pin,
  input  wire logic [NUM_EXT_INT-1:0] ext_int_n,
  input  wire logic [NUM_EXT_INT-1:0] ext_int_lvl_en,
  input  wire logic                   irq_service_start,
  input  wire logic                   wdt_timeout,
  output logic                        core_reset,
  output logic                        pc_load,
  output logic [15:0]                 pc_load_addr,
  output logic                        cpu_halt,
  output logic                        osc_stop,
  output logic                        bo_int_req,
  output logic [15:0]                 bo_int_vector,
  output logic                        wake_isr_start,
  output logic                        irq
);

  rps_state_t st_ff;
  rps_state_t nxt_st;
  logic       bo_qual;

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out qualification

  rps_bo_filter u_bo_filter (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .supply_low (supply_low),
    .bo_qual    (bo_qual)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic setup_rd;
  logic access_wr;
  logic access;
  logic mapped;

  assign access    = apb_req.psel && apb_req.penable;
  assign access_wr = access && apb_req.pwrite;
  assign setup_rd  = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

  always_comb
  begin
    case (apb_req.paddr)
      REG_FCFG, REG_WATCHDOG_CONTROL_REG, REG_POWER_CONTROL_REG, REG_STS, REG_MSK, REG_STATE, REG_AUXIE:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes, one per register except the read-only REG_STATE; unmapped writes match none of them

  logic wr_fcfg;
  logic wr_watchdog_control_reg;
  logic wr_power_control_reg;
  logic wr_sts;
  logic wr_msk;
  logic wr_auxie;

  assign wr_fcfg  = access_wr && (apb_req.paddr == REG_FCFG);
  assign wr_watchdog_control_reg  = access_wr && (apb_req.paddr == REG_WATCHDOG_CONTROL_REG);
  assign wr_power_control_reg  = access_wr && (apb_req.paddr == REG_POWER_CONTROL_REG);
  assign wr_sts   = access_wr && (apb_req.paddr == REG_STS);
  assign wr_msk   = access_wr && (apb_req.paddr == REG_MSK);
  assign wr_auxie = access_wr && (apb_req.paddr == REG_AUXIE);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, sampled in the setup cycle so prdata comes from a flop

  function automatic logic [31:0] read_word(input rps_state_t s, input logic [7:0] a,
                                            input logic q);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      REG_FCFG:  w[SWR_BIT]  = s.soft_reset_trigger;
      REG_WATCHDOG_CONTROL_REG:  w[WATCHDOG_RESET_FLAG_BIT] = s.watchdog_reset_flag;
      REG_AUXIE: w[EBO_BIT]  = s.brownout_irq_enable;
      REG_POWER_CONTROL_REG:
      begin
        w[IDL_BIT] = s.idle_request_bit;
        w[PD_BIT]  = s.pd;
      end
      REG_STS:   w[NUM_EV-1:0] = s.sts;
      REG_MSK:   w[NUM_EV-1:0] = s.msk;
      REG_STATE:
      begin
        w[ST_PS_LSB +: 2] = s.ps;
        w[ST_QUAL]        = q;
        w[ST_CRST]        = s.rcnt != 4'h0;
      end
      default:   w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualification, one slice per external interrupt pin

  logic [NUM_EXT_INT-1:0] pin_wake;

  generate
    for (genvar i = 0; i < NUM_EXT_INT; i++)
    begin : g_pin
      // Edge mode needs a running clock, so only level mode may wake
      assign pin_wake[i] = ext_int_lvl_en[i] && !ext_int_n[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Power state decode

  logic in_pdown;
  logic in_wake;
  logic svc_ok;

  assign in_pdown = st_ff.ps == PS_PDOWN;
  assign in_wake  = st_ff.ps == PS_WAKE;
  // No clock in power-down, so a service strobe there is stale
  // Wake counts as halted too: the core waits for the pin to rise
  assign svc_ok   = irq_service_start && !in_pdown && !in_wake;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic              soft_go;
  logic              bo_rst;
  logic              wake_lvl;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] w1c;

  always_comb
  begin
    nxt_st  = st_ff;
    soft_go = 1'b0;
    ev      = '0;
    w1c     = '0;

    nxt_st.pcld   = 1'b0;
    nxt_st.wake   = 1'b0;
    nxt_st.qual_d = bo_qual;

    wake_lvl = |pin_wake;

    // Reset whenever qualified brown-out meets a clear enable; this also
    // catches software clearing the enable while brown-out is still present
    bo_rst = bo_qual && !st_ff.brownout_irq_enable;

    if (setup_rd)
    begin
      nxt_st.rdata = read_word(st_ff, apb_req.paddr, bo_qual);
    end

    // Register writes; the bus never stalls, so each lands in one cycle
    if (wr_fcfg)
    begin
      nxt_st.soft_reset_trigger = apb_req.pwdata[SWR_BIT];
      soft_go    = !st_ff.soft_reset_trigger && apb_req.pwdata[SWR_BIT];
    end

    if (wr_watchdog_control_reg)
    begin
      nxt_st.watchdog_reset_flag = apb_req.pwdata[WATCHDOG_RESET_FLAG_BIT];
    end

    if (wr_auxie)
    begin
      nxt_st.brownout_irq_enable = apb_req.pwdata[EBO_BIT];
    end

    if (wr_power_control_reg)
    begin
      // Set-only from software; hardware alone clears these
      nxt_st.idle_request_bit = st_ff.idle_request_bit | apb_req.pwdata[IDL_BIT];
      nxt_st.pd  = st_ff.pd | apb_req.pwdata[PD_BIT];
    end

    if (wr_sts)
    begin
      w1c = apb_req.pwdata[NUM_EV-1:0];
    end

    if (wr_msk)
    begin
      nxt_st.msk = apb_req.pwdata[NUM_EV-1:0];
    end

    // Watchdog flag: hardware set wins over a same-cycle write
    if (wdt_timeout)
    begin
      nxt_st.watchdog_reset_flag = 1'b1;
    end

    // Brown-out interrupt on the qualifying edge
    if (bo_qual && !st_ff.qual_d && st_ff.brownout_irq_enable)
    begin
      ev[EV_BO] = 1'b1;
    end

    // Interrupt servicing ends idle
    if (svc_ok)
    begin
      nxt_st.idle_request_bit = 1'b0;
      if (st_ff.ps == PS_IDLE)
      begin
        ev[EV_IDLE_END] = 1'b1;
      end
    end

    case (st_ff.ps)
      PS_RUN:
      begin
        if (st_ff.pd)
        begin
          nxt_st.ps = PS_PDOWN;
        end
        else if (st_ff.idle_request_bit)
        begin
          nxt_st.ps = PS_IDLE;
        end
      end
      PS_IDLE:
      begin
        if (st_ff.pd)
        begin
          nxt_st.ps = PS_PDOWN;
        end
        else if (!nxt_st.idle_request_bit)
        begin
          nxt_st.ps = PS_RUN;
        end
      end
      PS_PDOWN:
      begin
        if (wake_lvl)
        begin
          nxt_st.ps = PS_WAKE;
        end
      end
      PS_WAKE:
      begin
        // Oscillator runs again; pin is trusted to stay low long enough
        if (!wake_lvl)
        begin
          nxt_st.ps       = PS_RUN;
          nxt_st.wake     = 1'b1;
          nxt_st.pd       = 1'b0;
          nxt_st.idle_request_bit      = 1'b0;
          ev[EV_WAKE]     = 1'b1;
        end
      end
      default: nxt_st.ps = PS_RUN;
    endcase

    // Status: event set wins over a write-one clear
    nxt_st.sts = (st_ff.sts & ~w1c) | ev;

    // Reset pulse countdown ending in a PC load
    if (st_ff.rcnt != 4'h0)
    begin
      nxt_st.rcnt = st_ff.rcnt - 4'h1;
      nxt_st.pcld = st_ff.rcnt == 4'h1;
    end

    if (rst_pin || bo_rst)
    begin
      // Pin reset behaves as power-on; brown-out reset likewise
      nxt_st        = RPS_STATE_RST;
      nxt_st.rcnt   = RST_PULSE;
      nxt_st.qual_d = bo_qual;
    end
    else if (soft_go)
    begin
      nxt_st        = RPS_STATE_RST;
      nxt_st.soft_reset_trigger    = 1'b1;
      nxt_st.watchdog_reset_flag   = st_ff.watchdog_reset_flag | wdt_timeout;
      nxt_st.rcnt   = RST_PULSE;
      nxt_st.qual_d = bo_qual;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= RPS_STATE_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.prdata  = st_ff.rdata;
  assign apb_rsp.pslverr = access && !mapped;

  assign core_reset     = st_ff.rcnt != 4'h0;
  assign pc_load        = st_ff.pcld;
  // Fixed vectors; the core decides when to fetch from them
  assign pc_load_addr   = RESET_VEC;
  // Idle halts only the PC; peripherals keep their clock
  assign cpu_halt       = st_ff.ps != PS_RUN;
  assign osc_stop       = in_pdown;
  assign bo_int_req     = st_ff.sts[EV_BO];
  assign bo_int_vector  = BO_VEC;
  assign wake_isr_start = st_ff.wake;
  assign irq            = |(st_ff.sts & st_ff.msk);

endmodule

// *** tb/rps_chk_sva.sv ***
// Port checker for the reset and power-save sequencer
`timescale 1ns/1ps
module rps_chk
  import rps_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   supply_low,
  input  wire logic                   rst_pin,
  input  wire logic [NUM_EXT_INT-1:0] ext_int_n,
  input  wire logic [NUM_EXT_INT-1:0] ext_int_lvl_en,
  input  wire logic                   core_reset,
  input  wire logic                   pc_load,
  input  wire logic [15:0]            pc_load_addr,
  input  wire logic                   cpu_halt,
  input  wire logic                   osc_stop,
  input  wire logic                   bo_int_req,
  input  wire logic [15:0]            bo_int_vector,
  input  wire logic                   wake_isr_start
);
  wire logic wake_lvl = |(~ext_int_n & ext_int_lvl_en);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  //////////////////////////////
  a_bo_four_low: assert property ($rose(bo_int_req) |-> $past(supply_low, 2) &&
    $past(supply_low, 3) && $past(supply_low, 4) && $past(supply_low, 5)) else $error("short dip");
  a_bo_vec_fixed: assert property (bo_int_req |-> bo_int_vector == BO_VEC) else $error("bo vec");
  a_pc_load_zero: assert property ($fell(core_reset) |-> pc_load && pc_load_addr == RESET_VEC)
    else $error("pc load");
  a_pin_pulse_len: assert property (rst_pin |=> core_reset[*8]) else $error("pulse len");
  a_pin_ends_halt: assert property (rst_pin |=> !cpu_halt && !osc_stop) else $error("halt");
  a_pd_halts_cpu: assert property (osc_stop |-> cpu_halt) else $error("pd no halt");
  a_pd_exit_cause: assert property ($fell(osc_stop) |-> $past(wake_lvl) || $past(rst_pin) ||
    $past(supply_low)) else $error("pd exit");
  a_wake_one_pulse: assert property (wake_isr_start |-> $past(cpu_halt) && !cpu_halt
    ##1 !wake_isr_start) else $error("wake pulse");
endmodule
bind rps_top rps_chk chk_u (.sys_clk(sys_clk), .rst(rst), .supply_low(supply_low),
  .rst_pin(rst_pin), .ext_int_n(ext_int_n), .ext_int_lvl_en(ext_int_lvl_en),
  .core_reset(core_reset), .pc_load(pc_load), .pc_load_addr(pc_load_addr), .cpu_halt(cpu_halt),
  .osc_stop(osc_stop), .bo_int_req(bo_int_req), .bo_int_vector(bo_int_vector),
  .wake_isr_start(wake_isr_start));

// *** tb/rps_far_model.sv ***
// Model of the interrupt pins, reset pin and supply comparator
`timescale 1ns/1ps
module rps_far_model
  import rps_pkg::*;
(
  input  wire logic                   sys_clk,
  output logic                        supply_low,
  output logic                        rst_pin,
  output logic [NUM_EXT_INT-1:0]      ext_int_n
);
  // Interrupt pins have pull-ups, so idle means high; rst_pin idles low
  initial
  begin
    supply_low = 1'b0;
    rst_pin    = 1'b0;
    ext_int_n  = '1;
  end
  task automatic sag(input logic v);
    @(posedge sys_clk);
    supply_low <= v;
  endtask
  task automatic dip(input int n);
    sag(1'b1);
    repeat (n) @(posedge sys_clk);
    supply_low <= 1'b0;
  endtask
  task automatic pin_rst();
    @(posedge sys_clk);
    rst_pin <= 1'b1;
    @(posedge sys_clk);
    rst_pin <= 1'b0;
  endtask
  task automatic wake(input int i, input int n);
    @(posedge sys_clk);
    ext_int_n[i] <= 1'b0;
    repeat (n) @(posedge sys_clk);
    ext_int_n[i] <= 1'b1;
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the reset and power-save sequencer
`timescale 1ns/1ps
module tb;
  import rps_pkg::*;
  logic                   sys_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   svc = 1'b0;
  logic                   wdt = 1'b0;
  logic                   supply_low, rst_pin, core_reset, cpu_halt, osc_stop;
  logic                   bo_int_req, wake_isr_start, irq;
  logic [NUM_EXT_INT-1:0] ext_int_n;
  logic [NUM_EXT_INT-1:0] lvl_en = 2'h1;
  rps_apb_req_t           req = '0;
  rps_apb_rsp_t           rsp;
  logic [32:0]            exp_q[$];
  int                     error_cnt = 0;
  int                     comparisons = 0;
  int                     cycles = 0;
  int                     seed = 15484;
  always #12.5 sys_clk = ~sys_clk;
  rps_far_model far_u (.sys_clk(sys_clk), .supply_low(supply_low), .rst_pin(rst_pin),
    .ext_int_n(ext_int_n));
  rps_top dut_u (.sys_clk(sys_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .supply_low(supply_low), .rst_pin(rst_pin), .ext_int_n(ext_int_n), .ext_int_lvl_en(lvl_en),
    .irq_service_start(svc), .wdt_timeout(wdt), .core_reset(core_reset), .pc_load(),
    .pc_load_addr(), .cpu_halt(cpu_halt), .osc_stop(osc_stop), .bo_int_req(bo_int_req),
    .bo_int_vector(), .wake_isr_start(wake_isr_start), .irq(irq));
  //////////////////////////////
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] s);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    @(posedge sys_clk);
    while (rsp.pready !== 1'b1) @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic pulse(input bit to_svc);
    if (to_svc)
      svc <= 1'b1;
    else
      wdt <= 1'b1;
    @(posedge sys_clk);
    svc <= 1'b0;
    wdt <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Read results are judged where they appear, in issue order
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (req.psel && req.penable && !req.pwrite && rsp.pready && exp_q.size() > 0)
      cmp("prdata", exp_q.pop_front(), {rsp.pslverr, rsp.prdata});
    if (cycles == 6000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  initial
  begin
    step(5);
    rst <= 1'b0;
    step(1);
    rd(REG_STATE, 33'h0);
    rd(8'h40, {1'b1, 32'h0});
    apb(1'b1, 8'h44, $random(seed));
    far_u.dip(3);
    step(4);
    cmp("core_reset", 0, core_reset);
    apb(1'b1, REG_MSK, 32'h1);
    apb(1'b1, REG_AUXIE, ($random(seed) & 32'hffff_fff7) | 32'h8);
    far_u.sag(1'b1);
    step(6);
    cmp("bo_int_req", 1, bo_int_req);
    cmp("irq", 1, irq);
    cmp("core_reset", 0, core_reset);
    far_u.sag(1'b0);
    apb(1'b1, REG_MSK, 32'h0);
    cmp("irq", 0, irq);
    apb(1'b1, REG_STS, 32'h1);
    cmp("bo_int_req", 0, bo_int_req);
    far_u.sag(1'b1);
    step(6);
    apb(1'b1, REG_AUXIE, 32'h0);
    step(2);
    cmp("core_reset", 1, core_reset);
    step(20);
    cmp("core_reset", 1, core_reset);
    far_u.sag(1'b0);
    step(12);
    rd(REG_STS, 33'h0);
    pulse(1'b0);
    apb(1'b1, REG_AUXIE, 32'h8);
    apb(1'b1, REG_FCFG, 32'h2);
    step(2);
    cmp("core_reset", 1, core_reset);
    step(10);
    rd(REG_FCFG, 33'h2);
    rd(REG_WATCHDOG_CONTROL_REG, 33'h4);
    rd(REG_AUXIE, 33'h0);
    apb(1'b1, REG_FCFG, 32'h2);
    step(2);
    cmp("core_reset", 0, core_reset);
    apb(1'b1, REG_POWER_CONTROL_REG, 32'h1);
    step(2);
    cmp("cpu_halt", 1, cpu_halt);
    cmp("osc_stop", 0, osc_stop);
    pulse(1'b1);
    step(2);
    cmp("cpu_halt", 0, cpu_halt);
    rd(REG_POWER_CONTROL_REG, 33'h0);
    apb(1'b1, REG_POWER_CONTROL_REG, 32'h3);
    step(2);
    cmp("osc_stop", 1, osc_stop);
    pulse(1'b1);
    far_u.wake(1, 20);
    step(2);
    cmp("osc_stop", 1, osc_stop);
    fork
      far_u.wake(0, 1024);
      begin
        step(10);
        cmp("osc_stop", 0, osc_stop);
        cmp("cpu_halt", 1, cpu_halt);
      end
    join
    step(2);
    cmp("wake_isr_start", 1, wake_isr_start);
    rd(REG_POWER_CONTROL_REG, 33'h0);
    rd(REG_STS, 33'h6);
    apb(1'b1, REG_POWER_CONTROL_REG, 32'h1);
    step(2);
    far_u.pin_rst();
    step(2);
    cmp("cpu_halt", 0, cpu_halt);
    cmp("core_reset", 1, core_reset);
    step(12);
    wrap_up();
  end
endmodule
